// file: sleep_wake_pkg.sv
// Constants and types shared by the sleep and wake controller
package sleep_wake_pkg;
    // Register indices; each byte address is four times its index
    localparam logic [13:0] OPTION_IDX = 14'h0081;
    localparam logic [13:0] CONFIG_IDX = 14'h2007;
    localparam logic [13:0] STATUS_IDX = 14'h0003;
    localparam logic [15:0] OPTION_ADDR = {OPTION_IDX, 2'b00};
    localparam logic [15:0] CONFIG_ADDR = {CONFIG_IDX, 2'b00};
    localparam logic [15:0] STATUS_ADDR = {STATUS_IDX, 2'b00};

    // Reset value of the option register
    localparam logic [7:0] OPTION_RST = 8'hff;

    // Field positions
    localparam int OPT_PSA = 3;
    localparam int OPT_PS_LO = 0;
    localparam int CFG_WATCHDOG_FUSE_ENABLE = 2;
    localparam int CFG_FOSC_LO = 0;
    localparam int STAT_TO = 4;
    localparam int STAT_PD = 3;
    localparam int STAT_ST_LO = 0;

    // Oscillator select code of the RC mode
    localparam logic [1:0] OSC_RC = 2'h3;

    // Interrupt vector reached after an enabled interrupt wake
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;

    // Oscillator start-up delay in oscillator periods, then in clocks
    localparam int OST_TOSC = 1024;
    localparam int OSC_PERIOD_NS = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam int OST_CYCLES = (OST_TOSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

    // Watchdog base period in watchdog oscillator ticks
    localparam logic [19:0] WDT_BASE_TICKS = 20'h0_0100;

    // Controller states, Gray coded along run, exec, sleep, start-up
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_EXEC = 2'b01,
        ST_SLEEP = 2'b11,
        ST_OST = 2'b10
    } state_t;
endpackage

// file: sleep_wake_controller.sv
// Sleep entry, wake-up and watchdog control for a small core
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns

module sleep_wake_controller
    import sleep_wake_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // AHB-Lite register port
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Core side
    input wire logic sleep_instr_in,
    input wire logic watchdog_clear_instr_in,
    input wire logic global_irq_enable_in,
    input wire logic [2:0] irq_flag_in,
    input wire logic [2:0] irq_enable_in,
    input wire logic [7:0] config_word_in,
    input wire logic master_clear_pin_n_in,
    output logic master_clear_pin_out,
    output logic master_clear_pin_oe_n_out,
    input wire logic watchdog_tick_in,
    output logic core_run_out,
    output logic osc_driver_en_out,
    output logic io_hold_out,
    output logic prefetch_next_out,
    output logic device_reset_out,
    output logic vector_after_next_out,
    output logic [12:0] vector_addr_out
);

    state_t state_q;
    state_t state_d;
    logic [7:0] option_q;
    logic [7:0] cfg_q;
    logic power_down_q;
    logic timeout_q;
    logic device_reset_q;
    logic vector_q;
    logic irq_wake_q;
    logic [19:0] wdt_cnt_q;
    logic [10:0] ost_cnt_q;
    logic dphase_q;
    logic wr_pend_q;
    logic [31:0] waddr_q;
    logic [31:0] hrdata_q;
    logic wake_pending;
    logic nop_sleep;
    logic sleep_go;
    logic wdt_en;
    logic wdt_expire;
    logic wdt_clear;
    logic rc_mode;
    logic leaving;
    logic irq_now;
    logic resume;
    logic addr_ok;

    // Address decode shared by read and write paths
    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] reg_addr);
        reg_hit = (addr[31:16] == 16'h0000) && (addr[15:0] == reg_addr);
    endfunction

    // Watchdog limit, lengthened when the prescaler is assigned to it
    function automatic logic [19:0] wdt_limit(input logic [7:0] opt);
        if (opt[OPT_PSA]) begin
            wdt_limit = WDT_BASE_TICKS << opt[OPT_PS_LO +: 3];
        end else begin
            wdt_limit = WDT_BASE_TICKS;
        end
    endfunction

    // three interrupt wake sources
    // Only edge pin, port change and EEPROM done reach this mask
    assign wake_pending = |(irq_flag_in & irq_enable_in);

    assign nop_sleep = wake_pending && !global_irq_enable_in;

    // entry only on instruction
    // Master clear and a running-mode expiry both outrank the instruction
    assign sleep_go = ce_in && state_q == ST_RUN && sleep_instr_in && !nop_sleep
                      && master_clear_pin_n_in && !wdt_expire;

    assign prefetch_next_out = sleep_go;

    assign wdt_en = cfg_q[CFG_WATCHDOG_FUSE_ENABLE];
    assign wdt_expire = wdt_en && watchdog_tick_in && (wdt_cnt_q == wdt_limit(option_q) - 20'h0_0001);

    assign wdt_clear = sleep_go || (ce_in && state_q == ST_RUN && watchdog_clear_instr_in);

    assign rc_mode = cfg_q[CFG_FOSC_LO +: 2] == OSC_RC;

    // Next state of the sleep sequence
    always_comb begin
        state_d = state_q;
        if (!master_clear_pin_n_in) begin
            // master clear restarts oscillator and raises reset on the same edge
            if (state_q == ST_EXEC || state_q == ST_SLEEP) begin
                state_d = rc_mode ? ST_RUN : ST_OST;
            end
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (sleep_go) begin
                        state_d = ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (wake_pending) begin
                        state_d = rc_mode ? ST_RUN : ST_OST;
                    end else begin
                        state_d = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wdt_expire || wake_pending) begin
                        state_d = rc_mode ? ST_RUN : ST_OST;
                    end
                end
                ST_OST: begin
                    // core waits for a stable oscillator
                    if (ost_cnt_q == OST_LAST) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    // State register; the clock enable freezes the whole sequence
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= ST_RUN;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    // Start-up delay counter, cleared whenever outside the wait
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ost_cnt_q <= 11'h000;
        end else if (ce_in) begin
            if (state_q == ST_OST) begin
                ost_cnt_q <= ost_cnt_q + 11'h001;
            end else begin
                ost_cnt_q <= 11'h000;
            end
        end
    end

    // Watchdog counter; it keeps counting in sleep on its own ticks
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wdt_cnt_q <= 20'h0_0000;
        end else if (ce_in) begin
            if (wdt_clear || wdt_expire || !master_clear_pin_n_in) begin
                wdt_cnt_q <= 20'h0_0000;
            end else if (wdt_en && watchdog_tick_in) begin
                wdt_cnt_q <= wdt_cnt_q + 20'h0_0001;
            end
        end
    end

    // Power-down flag
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            power_down_q <= 1'b1;
        end else if (ce_in && sleep_go) begin
            power_down_q <= 1'b0;
        end
    end

    // Timeout flag; an expiry beats the set on entry
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            timeout_q <= 1'b1;
        end else if (ce_in) begin
            if (wdt_expire) begin
                timeout_q <= 1'b0;
            end else if (sleep_go) begin
                timeout_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            device_reset_q <= 1'b1;
        end else if (ce_in) begin
            device_reset_q <= !master_clear_pin_n_in || (wdt_expire && state_q != ST_SLEEP);
        end
    end

    assign leaving = (state_q == ST_EXEC || state_q == ST_SLEEP) && state_d != state_q;
    assign irq_now = leaving && master_clear_pin_n_in && wake_pending && !wdt_expire;
    assign resume = ce_in && master_clear_pin_n_in && state_q != ST_RUN && state_d == ST_RUN;

    // Remember an interrupt wake across the start-up wait
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_wake_q <= 1'b0;
        end else if (ce_in) begin
            if (resume || !master_clear_pin_n_in) begin
                irq_wake_q <= 1'b0;
            end else if (irq_now) begin
                irq_wake_q <= 1'b1;
            end
        end
    end

    // vector after next instruction
    // Global enable is sampled at resume, when the core reads it anyway
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            vector_q <= 1'b0;
        end else if (ce_in) begin
            vector_q <= resume && (irq_wake_q || irq_now) && global_irq_enable_in;
        end
    end

    // Fuse word is taken while reset is held
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg_q <= config_word_in;
        end
    end

    // AHB-Lite address phase accepted only when the block runs
    assign addr_ok = hsel_in && htrans_in[1] && hready_in && ce_in;

    // Bus phase tracking and read data capture
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dphase_q <= 1'b0;
            wr_pend_q <= 1'b0;
            waddr_q <= 32'h0000_0000;
            hrdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            dphase_q <= addr_ok;
            wr_pend_q <= addr_ok && hwrite_in;
            if (addr_ok) begin
                waddr_q <= haddr_in;
            end
            if (addr_ok && !hwrite_in) begin
                hrdata_q <= 32'h0000_0000;
                if (reg_hit(haddr_in, OPTION_ADDR)) begin
                    hrdata_q[7:0] <= option_q;
                end else if (reg_hit(haddr_in, CONFIG_ADDR)) begin
                    hrdata_q[7:0] <= cfg_q;
                end else if (reg_hit(haddr_in, STATUS_ADDR)) begin
                    hrdata_q[STAT_TO] <= timeout_q;
                    hrdata_q[STAT_PD] <= power_down_q;
                    hrdata_q[STAT_ST_LO +: 2] <= state_q;
                end
            end
        end
    end

    // Option register; other offsets ignore writes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            option_q <= OPTION_RST;
        end else if (ce_in && wr_pend_q && reg_hit(waddr_q, OPTION_ADDR)) begin
            option_q <= hwdata_in[7:0];
        end
    end

    // Zero wait states; a frozen block stretches its data phase
    assign hreadyout_out = !dphase_q || ce_in;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;

    assign io_hold_out = state_q == ST_EXEC || state_q == ST_SLEEP;
    assign osc_driver_en_out = state_q == ST_RUN || state_q == ST_OST;
    assign core_run_out = state_q == ST_RUN;
    assign master_clear_pin_out = 1'b0;
    assign master_clear_pin_oe_n_out = 1'b1;
    assign device_reset_out = device_reset_q;
    assign vector_after_next_out = vector_q;
    assign vector_addr_out = VECTOR_ADDR;

    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_sleep_cmd;
        state_q == ST_RUN && ce_in && sleep_instr_in && master_clear_pin_n_in && !wdt_expire;
    endsequence

    sequence s_sleep_done;
        state_q == ST_EXEC && !power_down_q && timeout_q && !osc_driver_en_out && wdt_cnt_q == 20'h0_0000;
    endsequence

    a_entry_only_instr: assert property (state_q == ST_RUN && !sleep_instr_in |=> state_q != ST_EXEC)
        else $error("sleep entered without the sleep instruction");
    a_entry_effects: assert property (s_sleep_cmd ##0 !nop_sleep |=> s_sleep_done)
        else $error("sleep entry effects missing");
    a_pins_held: assert property (state_q == ST_SLEEP |-> io_hold_out && !core_run_out)
        else $error("pins not held while asleep");
    a_pin_not_driven: assert property (master_clear_pin_oe_n_out)
        else $error("master clear pin driven");
    a_irq_wakes: assert property (state_q == ST_SLEEP && ce_in && wake_pending |=> state_q != ST_SLEEP)
        else $error("enabled interrupt did not wake");
    a_clear_resets: assert property (!master_clear_pin_n_in && ce_in |=> device_reset_out)
        else $error("master clear did not reset");
    a_expiry_flag: assert property (wdt_expire && ce_in |=> !timeout_q)
        else $error("timeout flag not cleared on expiry");
    a_powerup_flags: assert property (@(posedge clock_in) disable iff (1'b0)
            rst_in |=> power_down_q && timeout_q)
        else $error("flags not set at power-up");
    a_prefetch: assert property (s_sleep_cmd ##0 !nop_sleep |-> prefetch_next_out)
        else $error("no prefetch during sleep");
    a_vector_runs: assert property (vector_after_next_out |-> core_run_out && $past(state_q) != ST_RUN)
        else $error("vector request outside resume");
    a_nop_sleep: assert property (s_sleep_cmd ##0 nop_sleep |=> state_q == ST_RUN
            && $stable(power_down_q) && $stable(timeout_q))
        else $error("no-op sleep changed state");
    a_late_irq: assert property (state_q == ST_EXEC && ce_in && wake_pending |=> state_q != ST_SLEEP)
        else $error("pending interrupt did not wake at once");
    a_ost_hold: assert property (state_q == ST_OST && ost_cnt_q != OST_LAST |=> state_q == ST_OST)
        else $error("start-up wait cut short");
    a_ost_end: assert property (state_q == ST_OST && ost_cnt_q == OST_LAST && ce_in |=> core_run_out)
        else $error("start-up wait overran");
    a_sleep_expiry: assert property (state_q == ST_SLEEP && wdt_expire && ce_in && master_clear_pin_n_in
            |=> !device_reset_out && state_q != ST_SLEEP)
        else $error("sleep expiry reset instead of waking");
    a_fuse_off: assert property (!cfg_q[CFG_WATCHDOG_FUSE_ENABLE] && master_clear_pin_n_in |=> !device_reset_out)
        else $error("disabled watchdog reset the device");

endmodule

// file: core_model.sv
// Behavioural model of the instruction core that sits beside the sleep controller
`timescale 1ns/1ns
module core_model (
    input wire logic clock_in,
    input wire logic prefetch_in,
    output logic sleep_instr_out,
    output logic wdt_clear_out,
    output logic gie_out,
    output logic [2:0] flag_out,
    output logic [2:0] enable_out
);
    // Idle core: no instruction, interrupts masked; only the tasks below drive these
    logic sleep_q = 1'b0;
    logic clr_q = 1'b0;
    logic gie_q = 1'b0;
    logic [2:0] flag_q = 3'h0;
    logic [2:0] enable_q = 3'h0;

    assign sleep_instr_out = sleep_q;
    assign wdt_clear_out = clr_q;
    assign gie_out = gie_q;
    assign flag_out = flag_q;
    assign enable_out = enable_q;

    // the slot after sleep carries a no-op here, so nothing else is issued
    task automatic exec_sleep(output logic pf);
        @(posedge clock_in);
        clr_q <= 1'b1;
        @(posedge clock_in);
        clr_q <= 1'b0;
        sleep_q <= 1'b1;
        // The core latches the prefetched word a quarter cycle after the edge
        #2 pf = prefetch_in;
        @(posedge clock_in);
        sleep_q <= 1'b0;
    endtask

    // Interrupt flags, enables and global enable; caller stands just after an edge
    task automatic set_irq(input logic [2:0] f, input logic [2:0] e, input logic g);
        flag_q <= f;
        enable_q <= e;
        gie_q <= g;
    endtask
endmodule

// file: sleep_wake_controller_tb_top.sv
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ns
module sleep_wake_controller_tb_top
    import sleep_wake_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] cfg = 8'h04;
    logic master_clear_pin_n = 1'b1;
    logic tick = 1'b0;
    logic tick_on = 1'b0;
    int n_rst = 0;
    logic p;
    logic [31:0] hrdata;
    logic hrdy, hresp, sleep_i, clr_i, global_irq_enable, master_clear_pin_o, master_clear_pin_oe_n;
    logic run, osc, hold, pf, drst, vec;
    logic [2:0] flg, en;
    logic [12:0] vaddr;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;

    always #4 clock_in = ~clock_in;

    // Watchdog oscillator: one tick every other cycle, slower than the core
    always @(posedge clock_in) tick <= tick_on & ~tick;

    // Count of device reset cycles; tests compare snapshots, so one process drives it
    always @(posedge clock_in) if (drst === 1'b1) n_rst++;

    // Run guard, well above the longest expected sequence
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("timeout after %0d cycles", cyc);
            final_report();
        end
    end

    sleep_wake_controller uut (
        .clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .sleep_instr_in(sleep_i), .watchdog_clear_instr_in(clr_i), .global_irq_enable_in(global_irq_enable),
        .irq_flag_in(flg), .irq_enable_in(en), .config_word_in(cfg),
        .master_clear_pin_n_in(master_clear_pin_n), .master_clear_pin_out(master_clear_pin_o),
        .master_clear_pin_oe_n_out(master_clear_pin_oe_n), .watchdog_tick_in(tick),
        .core_run_out(run), .osc_driver_en_out(osc), .io_hold_out(hold),
        .prefetch_next_out(pf), .device_reset_out(drst),
        .vector_after_next_out(vec), .vector_addr_out(vaddr)
    );

    core_model core_i (
        .clock_in(clock_in), .prefetch_in(pf), .sleep_instr_out(sleep_i),
        .wdt_clear_out(clr_i), .gie_out(global_irq_enable), .flag_out(flg), .enable_out(en)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; the master waits on hready at each phase
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [31:0] rd);
        @(posedge clock_in);
        hsel <= 1'b1;
        haddr <= {16'h0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        // Only the run guard ends a wait for the slave
        do begin @(posedge clock_in); end while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h00_0000, d};
        do begin @(posedge clock_in); end while (hrdy !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        bus(1'b0, a, 8'h00, v);
        chk(what, exp, v);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    // Fuse word is captured only while reset is held
    task automatic do_reset(input logic [7:0] c);
        @(posedge clock_in);
        rst_in <= 1'b1;
        cfg <= c;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask

    // Counts edges until the core runs; samples settled outputs, ends on an edge
    task automatic wait_run(input int lim, output int cnt, output logic v);
        cnt = 0;
        do begin @(posedge clock_in); #1; cnt++; end while (run !== 1'b1 && cnt < lim);
        v = vec;
        @(posedge clock_in);
    endtask

    task automatic t_regs();
        rd(STATUS_ADDR, 32'h0000_0018, "status after reset");
        rd(OPTION_ADDR, 32'h0000_00ff, "option reset");
        wr(OPTION_ADDR, 8'h5a);
        rd(OPTION_ADDR, 32'h0000_005a, "option rw");
        wr(CONFIG_ADDR, 8'hff);
        rd(CONFIG_ADDR, 32'h0000_0004, "config ro");
        rd(16'h0100, 32'h0000_0000, "unmapped");
        chk("run", 32'h0000_0001, {31'h0, run});
        chk("master_clear_pin oe", 32'h0000_0001, {31'h0, master_clear_pin_oe_n});
        chk("master_clear_pin level", 32'h0000_0000, {31'h0, master_clear_pin_o});
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        chk("vector", {19'h0, VECTOR_ADDR}, {19'h0, vaddr});
        $display("test regs done");
    endtask

    task automatic t_noop();
        core_i.set_irq(3'b001, 3'b001, 1'b0);
        core_i.exec_sleep(p);
        chk("noop prefetch", 32'h0000_0000, {31'h0, p});
        rd(STATUS_ADDR, 32'h0000_0018, "noop status");
        core_i.set_irq(3'b000, 3'b000, 1'b0);
        $display("test noop done");
    endtask

    task automatic t_ost();
        core_i.set_irq(3'b000, 3'b010, 1'b1);
        core_i.exec_sleep(p);
        chk("prefetch", 32'h0000_0001, {31'h0, p});
        #1 chk("asleep", 32'h0000_0001, {29'h0, run, osc, hold});
        rd(STATUS_ADDR, 32'h0000_0013, "sleep status");
        core_i.set_irq(3'b010, 3'b010, 1'b1);
        wait_run(1500, n, p);
        chk("start-up", 32'h0000_0401, 32'(n));
        chk("vector pulse", 32'h0000_0001, {31'h0, p});
        core_i.set_irq(3'b000, 3'b000, 1'b0);
        $display("test ost done");
    endtask

    task automatic t_wdt_run();
        int r0;
        r0 = n_rst;
        tick_on <= 1'b1;
        // Prescaler doubles the period; without it the watchdog would have fired by now
        repeat (700) @(posedge clock_in);
        chk("prescaled wait", 32'h0000_0000, 32'(n_rst - r0));
        repeat (400) @(posedge clock_in);
        tick_on <= 1'b0;
        chk("wdt reset", 32'h0000_0001, 32'(n_rst - r0));
        chk("master_clear_pin oe", 32'h0000_0001, {31'h0, master_clear_pin_oe_n});
        rd(STATUS_ADDR, 32'h0000_0008, "wdt reset status");
        $display("test wdt run done");
    endtask

    task automatic t_race();
        core_i.set_irq(3'b000, 3'b001, 1'b0);
        core_i.exec_sleep(p);
        core_i.set_irq(3'b001, 3'b001, 1'b0);
        wait_run(20, n, p);
        chk("race wake", 32'h0000_0001, 32'(n));
        rd(STATUS_ADDR, 32'h0000_0010, "race status");
        core_i.set_irq(3'b000, 3'b000, 1'b0);
        $display("test race done");
    endtask

    task automatic t_enable();
        core_i.set_irq(3'b100, 3'b000, 1'b1);
        core_i.exec_sleep(p);
        repeat (20) @(posedge clock_in);
        chk("masked stays", 32'h0000_0000, {31'h0, run});
        core_i.set_irq(3'b100, 3'b100, 1'b0);
        wait_run(20, n, p);
        chk("rc wake", 32'h0000_0001, 32'(n));
        chk("in line", 32'h0000_0000, {31'h0, p});
        core_i.set_irq(3'b000, 3'b000, 1'b0);
        $display("test enable done");
    endtask

    task automatic t_master_clear_pin();
        core_i.exec_sleep(p);
        master_clear_pin_n <= 1'b0;
        @(posedge clock_in);
        #1 chk("master_clear_pin reset", 32'h0000_0001, {31'h0, drst});
        @(posedge clock_in);
        master_clear_pin_n <= 1'b1;
        wait_run(20, n, p);
        rd(STATUS_ADDR, 32'h0000_0010, "master_clear_pin status");
        $display("test master_clear_pin done");
    endtask

    task automatic t_wdt_sleep();
        int r0;
        wr(OPTION_ADDR, 8'h00);
        core_i.exec_sleep(p);
        r0 = n_rst;
        tick_on <= 1'b1;
        wait_run(2000, n, p);
        tick_on <= 1'b0;
        chk("wdt woke", 32'h0000_0001, {31'h0, run});
        chk("no reset", 32'h0000_0000, 32'(n_rst - r0));
        rd(STATUS_ADDR, 32'h0000_0000, "wdt wake status");
        $display("test wdt sleep done");
    endtask

    task automatic t_wdt_off();
        int r0;
        wr(OPTION_ADDR, 8'h00);
        r0 = n_rst;
        tick_on <= 1'b1;
        repeat (1200) @(posedge clock_in);
        tick_on <= 1'b0;
        chk("fuse off", 32'h0000_0000, 32'(n_rst - r0));
        rd(STATUS_ADDR, 32'h0000_0018, "fuse off status");
        $display("test wdt off done");
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Crystal mode, then RC mode, then watchdog fuse off
    initial begin
        do_reset(8'h04);
        t_regs();
        t_noop();
        t_ost();
        do_reset(8'h07);
        wr(OPTION_ADDR, 8'h09);
        t_wdt_run();
        t_race();
        t_enable();
        t_master_clear_pin();
        t_wdt_sleep();
        do_reset(8'h03);
        t_wdt_off();
        final_report();
    end
endmodule
